// File: verilog/css_params.svh
// Constants of the card slot supply sequencer: offsets, fields, reset values.
// Assumes inclusion by bare name from the package and the testbench.
`ifndef CSS_PARAMS_SVH
`define CSS_PARAMS_SVH

`define CSS_ADDR_CTRL 16'hFE03
`define CSS_ADDR_TIMER 16'hFE04
`define CSS_ADDR_IRQ_STATUS 16'hFE0A
`define CSS_ADDR_IRQ_MASK 16'hFE0B
`define CSS_ADDR_CMD_FORCE 16'hFE0C

`define CSS_RST_CTRL 8'h00
`define CSS_RST_TIMER 8'h0F
`define CSS_RST_ZERO 8'h00

`define CSS_SEL_MSB 7
`define CSS_SEL_LSB 6
`define CSS_FAULT_MODE_BIT 5
`define CSS_READY_START_BIT 4
`define CSS_SUPPLY_GOOD_BIT 3
`define CSS_POWER_DOWN_BIT 0
`define CSS_OFF_MSB 7
`define CSS_OFF_LSB 4
`define CSS_SETTLE_MSB 3
`define CSS_SETTLE_LSB 0

`define CSS_IRQ_CARD_EVENT_BIT 6
`define CSS_IRQ_SETTLE_BIT 5
`define CSS_IRQ_DONE_BIT 0
`define CSS_FORCE_LOW_BIT 0
`define CSS_FORCE_HIGH_BIT 1

`define CSS_SEL_OFF 2'h0
`define CSS_SEL_1V8 2'h1
`define CSS_SEL_3V0 2'h2
`define CSS_SEL_5V0 2'h3

`define CSS_IN_CARD_EVENT 0
`define CSS_IN_SUPPLY_GOOD 1
`define CSS_IN_READY 2
`define CSS_IN_FAULT 3
`define CSS_IN_SLOW_CLK 4
`define CSS_IN_COUNT 5

`endif

// File: verilog/css_pkg.sv
// Types shared by the card slot supply sequencer modules.
// Assumes css_params.svh is on the include path.
`include "css_params.svh"
package css_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETTLE,
    ST_ACTIVE,
    ST_OFF_WAIT,
    ST_DEACT_RST,
    ST_DEACT_CLK,
    ST_DEACT_IO
  } seq_state_type;
  typedef logic [7:0] reg_byte_type;
endpackage

// File: verilog/slow_timer_if.sv
// Interface between the sequencer and one of its slow-tick down counters.
// Assumes both ends run on the same reference clock.
`timescale 1ns/1ps
`default_nettype none
interface slow_timer_if #(parameter int WIDTH = 4);
  logic load;
  logic [WIDTH-1:0] load_value;
  logic tick;
  logic expired;
  logic busy;
  modport ctrl (output load, output load_value, output tick, input expired, input busy);
  modport counter (input load, input load_value, input tick, output expired, output busy);
endinterface
`default_nettype wire

// File: verilog/slow_down_counter.sv
// Down counter of slow-clock ticks with a one-cycle expiry pulse.
// Assumes tick is a one-cycle pulse on the reference clock.
`timescale 1ns/1ps
`default_nettype none
module slow_down_counter #(parameter int WIDTH = 4) (
  input wire logic i_clk,
  input wire logic i_nrst,
  slow_timer_if.counter tmr
);
  logic [WIDTH-1:0] count_q;
  logic expired_q;

  if (WIDTH < 1) begin : g_width_check
    $error("slow_down_counter needs WIDTH of at least 1");
  end

  // A load always wins, so a new sequence never sees a stale count.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      count_q <= '0;
    end else if (tmr.load) begin
      count_q <= tmr.load_value;
    end else if (tmr.tick && (count_q != '0)) begin
      count_q <= count_q - WIDTH'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      expired_q <= 1'b0;
    end else begin
      expired_q <= !tmr.load && tmr.tick && (count_q == WIDTH'(1));
    end
  end

  assign tmr.expired = expired_q;
  assign tmr.busy = (count_q != '0);
endmodule
`default_nettype wire

// File: verilog/card_slot_supply_sequencer.sv
// Card slot supply sequencer: activation, settle check and deactivation.
// Assumes a 50 MHz reference clock and a 32768 Hz slow clock on a pin.
// Behaviour
// RULE_01 - Non-zero voltage code write starts activation.
// RULE_02 - Software writes both select bits at once.
// RULE_03 - Card event or supply-good loss deactivates; the code ignores a supply-good loss while in the settle state.
// RULE_04 - Lines shut down before supply goes off.
// RULE_05 - Software clears select after automatic deactivation.
// RULE_06 - Fault in mode 0 raises both commands.
// RULE_07 - Fault in mode 1 left to software.
// RULE_08 - Ready-start proceeds once supply good.
// RULE_09 - Without ready-start, settle expiry deactivates; the code does so only if supply good is low, else it goes active.
// RULE_10 - Supply-good status bit is read-only.
// RULE_11 - Power-down bit selects power-down mode.
// RULE_12 - Timeout without supply good flags, deactivates, clears.
// RULE_13 - Settle time is field times slow period.
// RULE_14 - Zero settle field waits ready-start and ready.
// RULE_15 - Software off waits off field slow periods.
// RULE_16 - Emergency deactivations skip the off delay.
// RULE_17 - Settle expiry sets flag, cleared on read.
// RULE_18 - Counters reload at each sequence start.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module card_slot_supply_sequencer (
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  input wire logic [15:0] I_ADDR,
  input wire css_pkg::reg_byte_type I_WR_DATA,
  input wire logic I_WR_EN,
  input wire logic I_RD_EN,
  input wire logic I_SLOW_CLK,
  input wire logic I_CARD_EVENT,
  input wire logic I_SUPPLY_GOOD,
  input wire logic I_COMPANION_READY,
  input wire logic I_SUPPLY_FAULT,
  output logic [7:0] O_RD_DATA,
  output logic [1:0] O_SUPPLY_SELECT,
  output logic O_CMD_SUPPLY_LOW_N,
  output logic O_CMD_SUPPLY_HIGH_N,
  output logic O_CARD_RST_RELEASE,
  output logic O_CARD_CLK_EN,
  output logic O_CARD_IO_EN,
  output logic O_SLOT_POWER_DOWN,
  output logic O_IRQ
);
  import css_pkg::*;

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [`CSS_IN_COUNT-1:0] meta_q;
  logic [`CSS_IN_COUNT-1:0] sync_q;
  logic [`CSS_IN_COUNT-1:0] prev_q;
  logic card_evt, good_s, good_fall, ready_s, fault_s, slow_tick;

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= {I_SLOW_CLK, I_SUPPLY_FAULT, I_COMPANION_READY, I_SUPPLY_GOOD, I_CARD_EVENT};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign card_evt = sync_q[`CSS_IN_CARD_EVENT] && !prev_q[`CSS_IN_CARD_EVENT];
  assign good_s = sync_q[`CSS_IN_SUPPLY_GOOD];
  assign good_fall = !good_s && prev_q[`CSS_IN_SUPPLY_GOOD];
  assign ready_s = sync_q[`CSS_IN_READY];
  assign fault_s = sync_q[`CSS_IN_FAULT];
  assign slow_tick = sync_q[`CSS_IN_SLOW_CLK] && !prev_q[`CSS_IN_SLOW_CLK];

  // ----------------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------------
  logic wr_ctrl, wr_timer, wr_mask, wr_force, rd_status;
  logic [1:0] wr_sel;

  assign wr_ctrl = I_WR_EN && (I_ADDR == `CSS_ADDR_CTRL);
  assign wr_timer = I_WR_EN && (I_ADDR == `CSS_ADDR_TIMER);
  assign wr_mask = I_WR_EN && (I_ADDR == `CSS_ADDR_IRQ_MASK);
  assign wr_force = I_WR_EN && (I_ADDR == `CSS_ADDR_CMD_FORCE);
  assign rd_status = I_RD_EN && (I_ADDR == `CSS_ADDR_IRQ_STATUS);
  assign wr_sel = I_WR_DATA[`CSS_SEL_MSB:`CSS_SEL_LSB];

  // ----------------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------------
  seq_state_type state_q, state_d;
  logic [1:0] sel_q;
  logic [1:0] active_sel_q;
  logic fault_mode_q, ready_start_q, power_down_q, lock_q, settle_zero_q;
  logic [7:0] timer_q;
  logic start_act, sw_off, in_run, emergency, settle_to_fail, settle_expired;

  slow_timer_if #(.WIDTH(4)) settle_tmr ();
  slow_timer_if #(.WIDTH(4)) off_tmr ();

  slow_down_counter #(.WIDTH(4)) u_settle_counter (
    .i_clk(I_REF_CLK),
    .i_nrst(I_NRST),
    .tmr(settle_tmr.counter)
  );

  slow_down_counter #(.WIDTH(4)) u_off_counter (
    .i_clk(I_REF_CLK),
    .i_nrst(I_NRST),
    .tmr(off_tmr.counter)
  );

  // RULE_02 and RULE_05 bind software; a locked slot ignores new codes.
  assign start_act = wr_ctrl && (wr_sel != `CSS_SEL_OFF) && (state_q == ST_IDLE) && !lock_q; // RULE_01
  assign sw_off = wr_ctrl && (wr_sel == `CSS_SEL_OFF) &&
                  ((state_q == ST_SETTLE) || (state_q == ST_ACTIVE));
  assign in_run = (state_q == ST_SETTLE) || (state_q == ST_ACTIVE) || (state_q == ST_OFF_WAIT);
  // Emergencies bypass the off delay and reach the line shutdown directly.
  assign emergency = in_run && (card_evt || (fault_s && !fault_mode_q) || // RULE_03 RULE_16
                     (good_fall && (state_q != ST_SETTLE)));
  assign settle_expired = (state_q == ST_SETTLE) && settle_tmr.expired;
  assign settle_to_fail = settle_expired && !good_s; // RULE_09 RULE_12

  assign settle_tmr.load = start_act; // RULE_18
  assign settle_tmr.load_value = timer_q[`CSS_SETTLE_MSB:`CSS_SETTLE_LSB]; // RULE_13
  assign settle_tmr.tick = slow_tick;
  assign off_tmr.load = sw_off; // RULE_18
  assign off_tmr.load_value = timer_q[`CSS_OFF_MSB:`CSS_OFF_LSB]; // RULE_15
  assign off_tmr.tick = slow_tick;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_act) begin
          state_d = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (emergency || settle_to_fail) begin
          state_d = ST_DEACT_RST;
        end else if (sw_off) begin
          state_d = (timer_q[`CSS_OFF_MSB:`CSS_OFF_LSB] == 4'h0) ? ST_DEACT_RST : ST_OFF_WAIT;
        end else if (settle_zero_q) begin
          if (ready_start_q && ready_s) begin
            state_d = ST_ACTIVE; // RULE_14
          end
        end else if ((ready_start_q && good_s) || settle_expired) begin
          state_d = ST_ACTIVE; // RULE_08
        end
      end
      ST_ACTIVE: begin
        if (emergency) begin
          state_d = ST_DEACT_RST;
        end else if (sw_off) begin
          state_d = (timer_q[`CSS_OFF_MSB:`CSS_OFF_LSB] == 4'h0) ? ST_DEACT_RST : ST_OFF_WAIT;
        end
      end
      ST_OFF_WAIT: begin
        if (emergency || off_tmr.expired) begin
          state_d = ST_DEACT_RST; // RULE_15 RULE_16
        end
      end
      ST_DEACT_RST: state_d = ST_DEACT_CLK; // RULE_04
      ST_DEACT_CLK: state_d = ST_DEACT_IO; // RULE_04
      ST_DEACT_IO: state_d = ST_IDLE; // RULE_04
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      active_sel_q <= `CSS_SEL_OFF;
      settle_zero_q <= 1'b0;
    end else if (start_act) begin
      active_sel_q <= wr_sel;
      settle_zero_q <= (timer_q[`CSS_SETTLE_MSB:`CSS_SETTLE_LSB] == 4'h0);
    end
  end

  // An automatic shutdown locks the slot until software writes a zero code.
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      lock_q <= 1'b0;
    end else if (emergency || settle_to_fail) begin
      lock_q <= 1'b1; // RULE_05
    end else if (wr_ctrl && (wr_sel == `CSS_SEL_OFF)) begin
      lock_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Control and configuration registers
  // ----------------------------------------------------------------------
  localparam reg_byte_type ctrl_reset_value = `CSS_RST_CTRL;

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      sel_q <= ctrl_reset_value[`CSS_SEL_MSB:`CSS_SEL_LSB];
      fault_mode_q <= ctrl_reset_value[`CSS_FAULT_MODE_BIT];
      ready_start_q <= ctrl_reset_value[`CSS_READY_START_BIT];
      power_down_q <= ctrl_reset_value[`CSS_POWER_DOWN_BIT];
    end else begin
      if (settle_to_fail) begin
        sel_q <= `CSS_SEL_OFF; // RULE_12
      end else if (wr_ctrl && (start_act || (wr_sel == `CSS_SEL_OFF) || state_q == ST_IDLE)) begin
        sel_q <= wr_sel;
      end
      if (wr_ctrl) begin
        fault_mode_q <= I_WR_DATA[`CSS_FAULT_MODE_BIT];
        ready_start_q <= I_WR_DATA[`CSS_READY_START_BIT];
        power_down_q <= I_WR_DATA[`CSS_POWER_DOWN_BIT]; // RULE_11
      end
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      timer_q <= `CSS_RST_TIMER;
    end else if (wr_timer) begin
      timer_q <= I_WR_DATA;
    end
  end

  logic [1:0] force_q;

  // Fault mode 1 leaves shutdown to software, which raises these forces.
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      force_q <= 2'h0;
    end else if (wr_force) begin
      force_q <= {I_WR_DATA[`CSS_FORCE_HIGH_BIT], I_WR_DATA[`CSS_FORCE_LOW_BIT]}; // RULE_07
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------------
  reg_byte_type status_q, mask_q, status_set;

  always_comb begin
    status_set = '0;
    status_set[`CSS_IRQ_CARD_EVENT_BIT] = card_evt || settle_to_fail; // RULE_12
    status_set[`CSS_IRQ_SETTLE_BIT] = settle_expired; // RULE_17
    status_set[`CSS_IRQ_DONE_BIT] = (state_q == ST_DEACT_IO);
  end

  // A read clears the flags, but an event in the same cycle still lands.
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      status_q <= `CSS_RST_ZERO;
    end else begin
      status_q <= (rd_status ? `CSS_RST_ZERO : status_q) | status_set; // RULE_17
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      mask_q <= `CSS_RST_ZERO;
    end else if (wr_mask) begin
      mask_q <= I_WR_DATA;
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  reg_byte_type rd_d;

  always_comb begin
    rd_d = '0;
    if (I_RD_EN) begin
      case (I_ADDR)
        `CSS_ADDR_CTRL: begin
          rd_d[`CSS_SEL_MSB:`CSS_SEL_LSB] = sel_q;
          rd_d[`CSS_FAULT_MODE_BIT] = fault_mode_q;
          rd_d[`CSS_READY_START_BIT] = ready_start_q;
          rd_d[`CSS_SUPPLY_GOOD_BIT] = good_s; // RULE_10
          rd_d[`CSS_POWER_DOWN_BIT] = power_down_q;
        end
        `CSS_ADDR_TIMER: rd_d = timer_q;
        `CSS_ADDR_IRQ_STATUS: rd_d = status_q;
        `CSS_ADDR_IRQ_MASK: rd_d = mask_q;
        `CSS_ADDR_CMD_FORCE: rd_d[1:0] = force_q;
        default: rd_d = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  logic supply_on, lines_on, low_n_d, high_n_d;

  assign supply_on = (state_q != ST_IDLE);
  assign lines_on = (state_q == ST_ACTIVE) || (state_q == ST_OFF_WAIT);

  always_comb begin
    low_n_d = !(supply_on && ((active_sel_q == `CSS_SEL_1V8) || (active_sel_q == `CSS_SEL_3V0)));
    high_n_d = !(supply_on && ((active_sel_q == `CSS_SEL_1V8) || (active_sel_q == `CSS_SEL_5V0)));
    if (fault_s && !fault_mode_q) begin
      low_n_d = 1'b1; // RULE_06
      high_n_d = 1'b1; // RULE_06
    end
    if (force_q[`CSS_FORCE_LOW_BIT]) begin
      low_n_d = 1'b1;
    end
    if (force_q[`CSS_FORCE_HIGH_BIT]) begin
      high_n_d = 1'b1;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_RD_DATA <= 8'h00;
      O_SUPPLY_SELECT <= `CSS_SEL_OFF;
      O_CMD_SUPPLY_LOW_N <= 1'b1;
      O_CMD_SUPPLY_HIGH_N <= 1'b1;
      O_CARD_RST_RELEASE <= 1'b0;
      O_CARD_CLK_EN <= 1'b0;
      O_CARD_IO_EN <= 1'b0;
      O_SLOT_POWER_DOWN <= 1'b0;
      O_IRQ <= 1'b0;
    end else begin
      O_RD_DATA <= rd_d;
      O_SUPPLY_SELECT <= supply_on ? active_sel_q : `CSS_SEL_OFF;
      O_CMD_SUPPLY_LOW_N <= low_n_d;
      O_CMD_SUPPLY_HIGH_N <= high_n_d;
      O_CARD_RST_RELEASE <= lines_on; // RULE_04
      O_CARD_CLK_EN <= lines_on || (state_q == ST_DEACT_RST); // RULE_04
      O_CARD_IO_EN <= lines_on || (state_q == ST_DEACT_RST) || (state_q == ST_DEACT_CLK);
      O_SLOT_POWER_DOWN <= power_down_q; // RULE_11
      O_IRQ <= |(status_q & mask_q);
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);

  chk_start_activation: assert property ( // RULE_01
    start_act |=> (state_q == ST_SETTLE) && (active_sel_q != `CSS_SEL_OFF))
    else $error("activation did not start on a non-zero code");

  chk_event_deact: assert property ( // RULE_03
    (in_run && card_evt) |=> (state_q == ST_DEACT_RST) ##1 !O_CARD_RST_RELEASE)
    else $error("card event did not force deactivation");

  chk_deact_order: assert property ( // RULE_04
    (state_q == ST_DEACT_RST) |=> (state_q == ST_DEACT_CLK) ##1 (state_q == ST_DEACT_IO)
      ##1 (state_q == ST_IDLE) ##1 !O_CARD_IO_EN)
    else $error("deactivation steps out of order");

  chk_lines_before_supply: assert property ( // RULE_04
    $rose(O_SUPPLY_SELECT == `CSS_SEL_OFF) |-> !O_CARD_CLK_EN && !O_CARD_IO_EN && !O_CARD_RST_RELEASE)
    else $error("supply removed while card lines active");

  chk_fault_cmd_high: assert property ( // RULE_06
    (fault_s && !fault_mode_q) |=> O_CMD_SUPPLY_LOW_N && O_CMD_SUPPLY_HIGH_N)
    else $error("supply commands not raised on fault");

  chk_ready_start: assert property ( // RULE_08
    ((state_q == ST_SETTLE) && !settle_zero_q && ready_start_q && good_s && !emergency && !sw_off)
      |=> (state_q == ST_ACTIVE))
    else $error("ready-start did not proceed on supply good");

  chk_timeout_clears: assert property ( // RULE_12
    settle_to_fail |=> (sel_q == `CSS_SEL_OFF) && status_q[`CSS_IRQ_CARD_EVENT_BIT]
      && (state_q == ST_DEACT_RST))
    else $error("settle failure not handled");

  chk_flag_clear: assert property ( // RULE_17
    (rd_status && (status_set == '0)) |=> (status_q == `CSS_RST_ZERO))
    else $error("status read did not clear flags");

  chk_emergency_no_delay: assert property ( // RULE_16
    ((state_q == ST_OFF_WAIT) && emergency) |=> (state_q == ST_DEACT_RST))
    else $error("emergency waited for the off delay");

  chk_settle_timer_runs: assert property ( // RULE_13
    ((state_q == ST_SETTLE) && !settle_zero_q) |-> settle_tmr.busy || settle_tmr.expired)
    else $error("settle timer idle during settle wait");

  chk_off_timer_runs: assert property ( // RULE_15
    (state_q == ST_OFF_WAIT) |-> off_tmr.busy || off_tmr.expired)
    else $error("off delay timer idle during off wait");
endmodule
`default_nettype wire

// File: dv/companion_model.sv
// Behavioural model of the companion power interface circuit.
// Assumes the bench reference clock; the supply rises a fixed count after a command.
`timescale 1ns/1ps
`default_nettype none
module companion_model #(parameter int RISE = 30) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_cmd_low_n,
  input wire logic i_cmd_high_n,
  input wire logic i_fail,
  output logic o_supply_good,
  output logic o_ready
);
  int rise_q;
  // The supply collapses at once when both commands go high or a failure is injected.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) rise_q <= 0;
    else if (i_fail || (i_cmd_low_n && i_cmd_high_n)) rise_q <= 0;
    else if (rise_q < RISE) rise_q <= rise_q + 1;
  end
  assign o_supply_good = (rise_q == RISE);
  assign o_ready = o_supply_good;
endmodule
`default_nettype wire

// File: dv/card_slot_supply_sequencer_tb.sv
// Self-checking bench of the card slot supply sequencer.
// Assumes the design files and css_params.svh; slow clock is sped up to 40 cycles a tick.
`timescale 1ns/1ps
`default_nettype none
`include "css_params.svh"
module card_slot_supply_sequencer_tb;
  import css_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, slow = 1'b0;
  logic evt = 1'b0, flt = 1'b0, fail = 1'b0, good, rdy;
  logic [15:0] addr = 16'h0000;
  reg_byte_type wdata = 8'h00;
  logic [7:0] rdata;
  logic [1:0] sel;
  logic low_n, high_n, rst_rel, clk_en, io_en, pdn, irq;
  int n_mismatch = 0, checks_done = 0;

  card_slot_supply_sequencer i_dut (.I_REF_CLK(clk), .I_NRST(nrst), .I_ADDR(addr),
    .I_WR_DATA(wdata), .I_WR_EN(wr), .I_RD_EN(rd), .I_SLOW_CLK(slow), .I_CARD_EVENT(evt),
    .I_SUPPLY_GOOD(good), .I_COMPANION_READY(rdy), .I_SUPPLY_FAULT(flt),
    .O_RD_DATA(rdata), .O_SUPPLY_SELECT(sel), .O_CMD_SUPPLY_LOW_N(low_n),
    .O_CMD_SUPPLY_HIGH_N(high_n), .O_CARD_RST_RELEASE(rst_rel), .O_CARD_CLK_EN(clk_en),
    .O_CARD_IO_EN(io_en), .O_SLOT_POWER_DOWN(pdn), .O_IRQ(irq));
  companion_model i_partner (.i_clk(clk), .i_nrst(nrst), .i_cmd_low_n(low_n),
    .i_cmd_high_n(high_n), .i_fail(fail), .o_supply_good(good), .o_ready(rdy));

  initial forever #10 clk = ~clk;
  // The slow clock is sped up to one tick every 40 reference cycles.
  int slow_cnt = 0;
  always @(posedge clk) begin
    slow_cnt <= (slow_cnt == 19) ? 0 : slow_cnt + 1;
    if (slow_cnt == 19) begin
      slow <= ~slow;
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input reg_byte_type d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Expected select code and both active-low commands for a voltage code.
  function automatic logic [3:0] sup(input logic [1:0] c);
    return {c, !(c == 2'h1 || c == 2'h2), !(c == 2'h1 || c == 2'h3)};
  endfunction
  function automatic logic [3:0] pick(input int w);
    case (w)
      0: return {sel, low_n, high_n};
      1: return {3'h0, rst_rel};
      default: return {2'h0, low_n, high_n};
    endcase
  endfunction
  task automatic wait_on(input int w, input logic [3:0] exp, input int n);
    int i;
    #1;
    for (i = 0; i < n && pick(w) !== exp; i++) begin
      @(posedge clk);
      #1;
    end
    chk({4'h0, pick(w)}, {4'h0, exp});
    if (pick(w) !== exp) report_and_stop();
  endtask
  task automatic clear_status();
    logic [7:0] d;
    rd_reg(`CSS_ADDR_IRQ_STATUS, d);
  endtask

  task automatic t_reset();
    logic [7:0] d;
    rd_reg(`CSS_ADDR_CTRL, d);
    chk(d, 8'h00);
    rd_reg(`CSS_ADDR_TIMER, d);
    chk(d, 8'h0F);
    rd_reg(`CSS_ADDR_IRQ_STATUS, d);
    chk(d, 8'h00);
    rd_reg(16'hFE10, d);
    chk(d, 8'h00);
    chk({4'h0, pick(0)}, {4'h0, sup(2'h0)});
    wr_reg(`CSS_ADDR_CTRL, 8'h09);
    rd_reg(`CSS_ADDR_CTRL, d);
    chk(d, 8'h01);
    chk({7'h0, pdn}, 8'h01);
    wr_reg(`CSS_ADDR_CTRL, 8'h00);
    rd_reg(`CSS_ADDR_CTRL, d);
    chk({7'h0, pdn}, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_act(input logic [1:0] c);
    logic [7:0] d;
    wr_reg(`CSS_ADDR_CTRL, {c, 6'h10});
    wait_on(0, sup(c), 10);
    wait_on(1, 4'h1, 100);
    rd_reg(`CSS_ADDR_CTRL, d);
    chk(d, {c, 6'h18});
    wr_reg(`CSS_ADDR_IRQ_MASK, 8'h01);
    wr_reg(`CSS_ADDR_CTRL, 8'h00);
    wait_on(1, 4'h0, 20);
    chk({4'h0, sel, clk_en, io_en}, {4'h0, c, 2'h3});
    wait_on(0, sup(2'h0), 10);
    repeat (2) @(posedge clk);
    #1 chk({7'h0, irq}, 8'h01);
    rd_reg(`CSS_ADDR_IRQ_STATUS, d);
    chk(d & 8'h01, 8'h01);
    repeat (3) @(posedge clk);
    #1 chk({7'h0, irq}, 8'h00);
    $display("test activation %0d done", c);
  endtask

  task automatic t_settle_fail();
    logic [7:0] d;
    @(posedge clk);
    fail <= 1'b1;
    wr_reg(`CSS_ADDR_TIMER, 8'h02);
    wr_reg(`CSS_ADDR_IRQ_MASK, 8'h60);
    wr_reg(`CSS_ADDR_CTRL, 8'h80);
    wait_on(0, sup(2'h2), 10);
    repeat (30) @(posedge clk);
    #1 chk({4'h0, pick(0)}, {4'h0, sup(2'h2)});
    wait_on(0, sup(2'h0), 150);
    repeat (2) @(posedge clk);
    #1 chk({7'h0, irq}, 8'h01);
    rd_reg(`CSS_ADDR_IRQ_STATUS, d);
    chk(d & 8'h60, 8'h60);
    rd_reg(`CSS_ADDR_IRQ_STATUS, d);
    chk(d, 8'h00);
    rd_reg(`CSS_ADDR_CTRL, d);
    chk(d & 8'hC0, 8'h00);
    wr_reg(`CSS_ADDR_CTRL, 8'h00);
    wr_reg(`CSS_ADDR_TIMER, 8'h00);
    wr_reg(`CSS_ADDR_CTRL, 8'h50);
    wait_on(0, sup(2'h1), 10);
    repeat (300) @(posedge clk);
    #1 chk({4'h0, pick(0)}, {4'h0, sup(2'h1)});
    @(posedge clk);
    fail <= 1'b0;
    wait_on(1, 4'h1, 100);
    wr_reg(`CSS_ADDR_CTRL, 8'h00);
    wait_on(0, sup(2'h0), 20);
    clear_status();
    $display("test settle done");
  endtask

  task automatic t_emergency();
    wr_reg(`CSS_ADDR_TIMER, 8'hF0);
    wr_reg(`CSS_ADDR_CTRL, 8'hD0);
    wait_on(1, 4'h1, 100);
    @(posedge clk);
    evt <= 1'b1;
    wait_on(0, sup(2'h0), 12);
    @(posedge clk);
    evt <= 1'b0;
    wr_reg(`CSS_ADDR_CTRL, 8'hD0);
    repeat (60) @(posedge clk);
    #1 chk({4'h0, pick(0)}, {4'h0, sup(2'h0)});
    wr_reg(`CSS_ADDR_CTRL, 8'h00);
    wr_reg(`CSS_ADDR_CTRL, 8'hD0);
    wait_on(1, 4'h1, 100);
    @(posedge clk);
    fail <= 1'b1;
    wait_on(0, sup(2'h0), 12);
    @(posedge clk);
    fail <= 1'b0;
    wr_reg(`CSS_ADDR_CTRL, 8'h00);
    wr_reg(`CSS_ADDR_CTRL, 8'hD0);
    wait_on(1, 4'h1, 100);
    wr_reg(`CSS_ADDR_CTRL, 8'h00);
    repeat (500) @(posedge clk);
    #1 chk({4'h0, pick(0)}, {4'h0, sup(2'h3)});
    wait_on(0, sup(2'h0), 260);
    clear_status();
    $display("test emergency done");
  endtask

  task automatic t_fault();
    wr_reg(`CSS_ADDR_CTRL, 8'h50);
    wait_on(1, 4'h1, 100);
    @(posedge clk);
    flt <= 1'b1;
    wait_on(2, 4'h3, 6);
    @(posedge clk);
    flt <= 1'b0;
    wr_reg(`CSS_ADDR_CTRL, 8'h00);
    wait_on(0, sup(2'h0), 20);
    wr_reg(`CSS_ADDR_CTRL, 8'h70);
    wait_on(1, 4'h1, 100);
    @(posedge clk);
    flt <= 1'b1;
    repeat (10) @(posedge clk);
    #1 chk({6'h0, low_n, high_n}, 8'h00);
    wr_reg(`CSS_ADDR_CMD_FORCE, 8'h03);
    wait_on(2, 4'h3, 4);
    @(posedge clk);
    flt <= 1'b0;
    wr_reg(`CSS_ADDR_CMD_FORCE, 8'h00);
    wr_reg(`CSS_ADDR_CTRL, 8'h00);
    wait_on(0, sup(2'h0), 20);
    clear_status();
    $display("test fault done");
  endtask

  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_act(2'h1);
    t_act(2'h2);
    t_act(2'h3);
    t_settle_fail();
    t_emergency();
    t_fault();
    report_and_stop();
  end
endmodule
`default_nettype wire
